// >>> hw/xad_pkg.sv
// constants shared by the xor and port direction instruction block
package xad_pkg;
	localparam int          INSTR_W        = 14;
	localparam int          DATA_W         = 8;
	localparam int          FADDR_W        = 7;
	// port direction load: 00 0000 0110 0fff
	localparam logic [10:0] DIR_LOAD_MATCH = 11'h00c;
	localparam int          DIR_SEL_W      = 3;
	localparam logic [2:0]  DIR_SEL_MIN    = 3'h5;
	localparam logic [2:0]  DIR_SEL_MAX    = 3'h7;
	localparam int          NUM_DIR        = 3;
	// literal xor: 11 1010 kkkk kkkk
	localparam logic [5:0]  XOR_LIT_OP     = 6'h3a;
	// file xor: 00 0110 dfff ffff
	localparam logic [5:0]  XOR_FILE_OP    = 6'h06;
	localparam int          DEST_BIT       = 7;
	// direction registers also live in the file map at these addresses
	localparam logic [6:0]  DIR_FADDR_BASE = 7'h05;
	localparam logic [7:0]  DIR_RESET      = 8'hff;
	localparam logic [7:0]  ACC_RESET      = 8'h00;
	localparam logic [1:0]  PHASE_DECODE   = 2'h0;
	localparam logic [1:0]  PHASE_READ     = 2'h1;
	localparam logic [1:0]  PHASE_PROC     = 2'h2;
	localparam logic [1:0]  PHASE_WRITE    = 2'h3;
endpackage

// >>> hw/xad_dir_reg.sv
// one port direction register, loadable by instruction or file write
`timescale 1ns/1ps
`default_nettype none
module xad_dir_reg
	import xad_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              load_i,
	input  wire logic [DATA_W-1:0] data_i,
	output logic      [DATA_W-1:0] value_o
);
	logic [DATA_W-1:0] value_q;
	logic [DATA_W-1:0] value_d;

	// next value: hold unless loaded
	always_comb begin
		value_d = load_i ? data_i : value_q;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			value_q <= DIR_RESET;
		end else begin
			value_q <= value_d;
		end
	end

	assign value_o = value_q;
endmodule
`default_nettype wire

// >>> hw/xad_core.sv
// decode and execute of direction load, literal xor and file xor
`timescale 1ns/1ps
`default_nettype none
module xad_core
	import xad_pkg::*;
(
	input  wire logic                        clk_i,
	input  wire logic                        reset_i,
	input  wire logic                        instr_valid_i,
	input  wire logic [xad_pkg::INSTR_W-1:0] instr_i,
	input  wire logic [xad_pkg::DATA_W-1:0]  file_rdata_i,
	output logic                             instr_ready_o,
	output logic      [xad_pkg::FADDR_W-1:0] file_addr_o,
	output logic                             file_rd_o,
	output logic                             file_we_o,
	output logic      [xad_pkg::DATA_W-1:0]  file_wdata_o,
	output logic      [xad_pkg::DATA_W-1:0]  acc_o,
	output logic                             zero_flag_o,
	output logic                             zero_we_o,
	output logic                             done_o,
	output logic      [xad_pkg::DATA_W-1:0]  dir_5_o,
	output logic      [xad_pkg::DATA_W-1:0]  dir_6_o,
	output logic      [xad_pkg::DATA_W-1:0]  dir_7_o
);
	typedef enum {OP_NONE, OP_DIR, OP_XLIT, OP_XFILE} xad_op_type;

	////////////////////////////////////////////////////////////////////
	// state
	logic [1:0]         phase_q, phase_d;
	xad_op_type         op_q, op_d;
	logic [INSTR_W-1:0] ir_q, ir_d;
	logic [DATA_W-1:0]  opnd_q, opnd_d;
	logic [DATA_W-1:0]  res_q, res_d;
	logic [DATA_W-1:0]  acc_q, acc_d;
	logic               zero_q, zero_d;
	logic               zwe_q, zwe_d;
	logic               done_q, done_d;
	logic               rdy_q, rdy_d;
	logic [FADDR_W-1:0] fa_q, fa_d;
	logic               frd_q, frd_d;
	logic               fwe_q, fwe_d;
	logic [DATA_W-1:0]  fwd_q, fwd_d;
	logic [NUM_DIR-1:0] dir_ld;
	logic [DATA_W-1:0]  dir_val [NUM_DIR];
	logic               dest_file;

	assign dest_file = ir_q[DEST_BIT];

	////////////////////////////////////////////////////////////////////
	// four-phase instruction cycle; a new word is taken only in decode
	always_comb begin
		phase_d = phase_q;
		op_d    = op_q;
		ir_d    = ir_q;
		opnd_d  = opnd_q;
		res_d   = res_q;
		acc_d   = acc_q;
		zero_d  = zero_q;
		zwe_d   = 1'b0;
		done_d  = 1'b0;
		rdy_d   = 1'b0;
		fa_d    = fa_q;
		frd_d   = 1'b0;
		fwe_d   = 1'b0;
		fwd_d   = fwd_q;
		dir_ld  = '0;
		case (phase_q)
			PHASE_DECODE: begin
				if (rdy_q && instr_valid_i) begin
					ir_d    = instr_i;
					phase_d = PHASE_READ;
					op_d    = OP_NONE;
					// unknown words still run all four phases but change nothing
					if (instr_i[INSTR_W-1:DIR_SEL_W] == DIR_LOAD_MATCH
						&& instr_i[DIR_SEL_W-1:0] >= DIR_SEL_MIN) begin
						op_d = OP_DIR;
					end else if (instr_i[INSTR_W-1:DATA_W] == XOR_LIT_OP) begin
						op_d = OP_XLIT;
					end else if (instr_i[INSTR_W-1:DATA_W] == XOR_FILE_OP) begin
						op_d  = OP_XFILE;
						fa_d  = instr_i[FADDR_W-1:0];
						frd_d = 1'b1;
					end
				end else begin
					rdy_d = 1'b1;
				end
			end
			PHASE_READ: begin
				phase_d = PHASE_PROC;
				// file data is taken in the same cycle that the read strobe stands
				opnd_d  = (op_q == OP_XFILE) ? file_rdata_i : ir_q[DATA_W-1:0];
			end
			PHASE_PROC: begin
				phase_d = PHASE_WRITE;
				res_d   = (op_q == OP_DIR) ? acc_q : (acc_q ^ opnd_q);
			end
			PHASE_WRITE: begin
				phase_d = PHASE_DECODE;
				rdy_d   = 1'b1;
				done_d  = 1'b1;
				case (op_q)
					OP_DIR: begin
						// flags untouched by direction load
						dir_ld[ir_q[1:0] - 2'h1] = 1'b1;
					end
					OP_XLIT: begin
						acc_d  = res_q;
						zero_d = (res_q == '0);
						zwe_d  = 1'b1;
					end
					OP_XFILE: begin
						zero_d = (res_q == '0);
						zwe_d  = 1'b1;
						if (dest_file) begin
							fwe_d = 1'b1;
							fwd_d = res_q;
						end else begin
							acc_d = res_q;
						end
					end
					default: begin
					end
				endcase
			end
			default: phase_d = PHASE_DECODE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase_q <= PHASE_DECODE;
			op_q    <= OP_NONE;
			ir_q    <= '0;
			opnd_q  <= '0;
			res_q   <= '0;
			acc_q   <= ACC_RESET;
			zero_q  <= 1'b0;
			zwe_q   <= 1'b0;
			done_q  <= 1'b0;
			rdy_q   <= 1'b0;
			fa_q    <= '0;
			frd_q   <= 1'b0;
			fwe_q   <= 1'b0;
			fwd_q   <= '0;
		end else begin
			phase_q <= phase_d;
			op_q    <= op_d;
			ir_q    <= ir_d;
			opnd_q  <= opnd_d;
			res_q   <= res_d;
			acc_q   <= acc_d;
			zero_q  <= zero_d;
			zwe_q   <= zwe_d;
			done_q  <= done_d;
			rdy_q   <= rdy_d;
			fa_q    <= fa_d;
			frd_q   <= frd_d;
			fwe_q   <= fwe_d;
			fwd_q   <= fwd_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// direction registers: instruction load or ordinary file write
	for (genvar g = 0; g < NUM_DIR; g++) begin : g_dir
		logic file_hit;
		// a file-xor with d=1 aimed at a direction address also lands here;
		// the next-value strobe keeps it on the same edge as every other write
		assign file_hit = fwe_d && (fa_q == DIR_FADDR_BASE + 7'(g));
		xad_dir_reg u_dir (
			.clk_i   (clk_i),
			.reset_i (reset_i),
			.load_i  (dir_ld[g] | file_hit),
			.data_i  (dir_ld[g] ? res_q : fwd_d),
			.value_o (dir_val[g])
		);
	end

	assign instr_ready_o = rdy_q;
	assign file_addr_o   = fa_q;
	assign file_rd_o     = frd_q;
	assign file_we_o     = fwe_q;
	assign file_wdata_o  = fwd_q;
	assign acc_o         = acc_q;
	assign zero_flag_o   = zero_q;
	assign zero_we_o     = zwe_q;
	assign done_o        = done_q;
	assign dir_5_o       = dir_val[0];
	assign dir_6_o       = dir_val[1];
	assign dir_7_o       = dir_val[2];

	////////////////////////////////////////////////////////////////////
	// checks
	a_lit_result: assert property (@(posedge clk_i) disable iff (reset_i)
		(rdy_q && instr_valid_i && instr_i[13:8] == XOR_LIT_OP)
		|-> ##4 (acc_q == ($past(acc_q, 4) ^ $past(instr_i[7:0], 4)) && zwe_q))
		else $error("literal xor result wrong");
	a_dir_load: assert property (@(posedge clk_i) disable iff (reset_i)
		(rdy_q && instr_valid_i && instr_i == 14'h0067)
		|-> ##5 (dir_7_o == $past(acc_q, 5)))
		else $error("direction load wrong");
	a_dir_noflag: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_q == OP_DIR) |-> !zwe_d)
		else $error("direction load touched flag");
	a_cycle_len: assert property (@(posedge clk_i) disable iff (reset_i)
		(rdy_q && instr_valid_i) |=> !done_q [*3] ##1 done_q)
		else $error("cycle length wrong");
	a_file_dest: assert property (@(posedge clk_i) disable iff (reset_i)
		(rdy_q && instr_valid_i && instr_i[13:8] == XOR_FILE_OP && instr_i[7])
		|-> ##4 (fwe_q && acc_q == $past(acc_q, 4)))
		else $error("file destination wrong");
	a_acc_dest: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_q == OP_XFILE && phase_q == PHASE_WRITE && !dest_file) |=> (acc_q == $past(res_q)))
		else $error("acc destination wrong");
	a_zero_flag: assert property (@(posedge clk_i) disable iff (reset_i)
		zwe_q |-> (zero_q == (fwe_q ? (fwd_q == 8'h00) : (acc_q == 8'h00))))
		else $error("zero flag wrong");
	a_file_read: assert property (@(posedge clk_i) disable iff (reset_i)
		(rdy_q && instr_valid_i && instr_i[13:8] == XOR_FILE_OP)
		|=> (frd_q && fa_q == $past(instr_i[6:0])))
		else $error("file read missing");
	c_lit: cover property (@(posedge clk_i) op_q == OP_XLIT && done_d);
	c_file_w: cover property (@(posedge clk_i) fwe_q);
	c_dir: cover property (@(posedge clk_i) |dir_ld);
endmodule
`default_nettype wire

// >>> sim/xor_and_port_direction_ops_tb.sv
// self-checking bench for the xor and port direction instruction block
`timescale 1ns/1ps
`default_nettype none
module xor_and_port_direction_ops_tb;
	import xad_pkg::*;
	logic               clk_i, reset_i, instr_valid_i;
	logic [INSTR_W-1:0] instr_i;
	logic [DATA_W-1:0]  file_rdata_i, acc_o, file_wdata_o, dir_5_o, dir_6_o, dir_7_o;
	logic [FADDR_W-1:0] file_addr_o;
	logic               instr_ready_o, file_rd_o, file_we_o, zero_flag_o, zero_we_o, done_o;
	logic [7:0]         acc_m;
	logic               zero_m;
	logic [7:0]         dir_m [5:7];
	logic [31:0]        seed;
	int                 n_fail = 0;
	int                 compares = 0;

	xad_core u_dut (
		.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .file_rdata_i(file_rdata_i), .instr_ready_o(instr_ready_o),
		.file_addr_o(file_addr_o), .file_rd_o(file_rd_o), .file_we_o(file_we_o),
		.file_wdata_o(file_wdata_o), .acc_o(acc_o), .zero_flag_o(zero_flag_o),
		.zero_we_o(zero_we_o), .done_o(done_o), .dir_5_o(dir_5_o), .dir_6_o(dir_6_o),
		.dir_7_o(dir_7_o)
	);

	// 250 mhz core clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// xorshift keeps the random stream identical on every run
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	function automatic logic [7:0] xor_of(input logic [7:0] a, input logic [7:0] b);
		return a ^ b;
	endfunction

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// flags are widened so an unknown still fails the case compare
	task automatic chk1(input string what, input logic exp, input logic got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask

	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// offer one word when ready, then step to the done pulse and check everything
	task automatic run(input logic [13:0] w, input logic [7:0] fv);
		int         k;
		logic [7:0] r;
		logic       lit, fil, dir, wr;
		lit = (w[13:8] == XOR_LIT_OP);
		fil = (w[13:8] == XOR_FILE_OP);
		dir = (w[13:3] == DIR_LOAD_MATCH) && (w[2:0] >= DIR_SEL_MIN);
		wr = fil && w[7];
		r = xor_of(acc_m, lit ? w[7:0] : fv);
		for (k = 0; k < 20 && instr_ready_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		if (k == 20) begin
			n_fail++;
			print_verdict();
		end
		instr_valid_i = 1'b1;
		instr_i = w;
		file_rdata_i = fv;
		@(posedge clk_i);
		#1;
		instr_valid_i = 1'b0;
		// the read strobe stands only in the cycle right after the take
		chk1("ready_taken", 1'b0, instr_ready_o);
		chk1("file_rd", fil, file_rd_o);
		if (fil) chk8("file_addr", {1'b0, w[6:0]}, {1'b0, file_addr_o});
		for (k = 1; k < 9; k++) begin
			@(posedge clk_i);
			#1;
			if (done_o === 1'b1) break;
		end
		chk8("done_cycle", 8'h03, 8'(k));
		chk1("ready_again", 1'b1, instr_ready_o);
		if (dir) dir_m[w[2:0]] = acc_m;
		if (wr && w[6:0] inside {[7'h05:7'h07]}) dir_m[w[2:0]] = r;
		if (lit || (fil && !w[7])) acc_m = r;
		if (lit || fil) zero_m = (r == 8'h00);
		chk8("acc", acc_m, acc_o);
		chk1("zero_we", lit || fil, zero_we_o);
		chk1("zero", zero_m, zero_flag_o);
		chk1("file_we", wr, file_we_o);
		if (wr) chk8("file_wdata", r, file_wdata_o);
		chk8("dir5", dir_m[5], dir_5_o);
		chk8("dir6", dir_m[6], dir_6_o);
		chk8("dir7", dir_m[7], dir_7_o);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// corner cases first, then a random instruction stream
	initial begin
		logic [13:0] w;
		reset_i = 1'b1;
		instr_valid_i = 1'b0;
		instr_i = 14'h0000;
		file_rdata_i = 8'h00;
		seed = 32'h000136db;
		acc_m = ACC_RESET;
		zero_m = 1'b0;
		dir_m = '{DIR_RESET, DIR_RESET, DIR_RESET};
		repeat (4) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		chk8("acc_reset", ACC_RESET, acc_o);
		chk8("dir_reset", DIR_RESET, dir_7_o);
		run(14'h3a5a, 8'h00);
		for (int f = 4; f < 8; f++) run({DIR_LOAD_MATCH, 3'(f)}, 8'h00);
		run(14'h3a5a, 8'h00);
		// direction register written by ordinary file addressing
		run({XOR_FILE_OP, 1'b1, 7'h06}, 8'h3c);
		run({XOR_FILE_OP, 1'b0, 7'h7f}, 8'hff);
		repeat (300) begin
			seed = xs(seed);
			w = {XOR_FILE_OP, seed[15:8]};
			if (seed[1:0] == 2'h1) w = {XOR_LIT_OP, seed[15:8]};
			if (seed[1:0] == 2'h2) w = {DIR_LOAD_MATCH, seed[10:8]};
			run(w, seed[23:16]);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
